// ### fch_host_model.sv
// host controller model: apb master that writes the four-byte output image
`timescale 1ns/1ps
module fch_host_model
(
    // clock
    input  wire logic        i_clk,
    // apb master side
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    // bus idle from time zero, host image starts at zero
    initial
    begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0000_0000;
    end

    // one transfer; the request stands until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= w;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        @(posedge i_clk);
        // no latency assumed: the bench watchdog bounds this wait
        while (i_pready !== 1'b1)
            @(posedge i_clk);
        q = i_prdata;
        e = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        // released data must not look like it still holds the old word
        o_pwdata  <= ~d;
    endtask
endmodule

// ### fch_pkg.sv
// constants and types for the fieldbus command handshake block
package fch_pkg;
    // register indices; byte address is four times the index
    localparam int IDX_TRIG     = 0;
    localparam int IDX_CMD      = 1;
    localparam int IDX_ARG      = 2;
    localparam int IDX_PIN_CLR  = 3;
    localparam int IDX_PIN_STO  = 4;
    localparam int IDX_IRQ_STAT = 5;
    localparam int IDX_IRQ_CLR  = 6;
    localparam int IDX_IRQ_EN   = 7;
    localparam int ADDR_W       = 8;
    localparam logic [7:0] ADR_TRIG     = 8'(IDX_TRIG * 4);
    localparam logic [7:0] ADR_CMD      = 8'(IDX_CMD * 4);
    localparam logic [7:0] ADR_ARG      = 8'(IDX_ARG * 4);
    localparam logic [7:0] ADR_PIN_CLR  = 8'(IDX_PIN_CLR * 4);
    localparam logic [7:0] ADR_PIN_STO  = 8'(IDX_PIN_STO * 4);
    localparam logic [7:0] ADR_IRQ_STAT = 8'(IDX_IRQ_STAT * 4);
    localparam logic [7:0] ADR_IRQ_CLR  = 8'(IDX_IRQ_CLR * 4);
    localparam logic [7:0] ADR_IRQ_EN   = 8'(IDX_IRQ_EN * 4);
    // reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [15:0] RST_PIN_CLR = 16'h00a5;
    localparam logic [15:0] RST_PIN_STO = 16'h04d2;
    // response high byte codes
    localparam logic [7:0] RSP_IDLE = 8'h00;
    localparam logic [7:0] RSP_RECV = 8'h01;
    localparam logic [7:0] RSP_ACK  = 8'h10;
    localparam logic [7:0] RSP_NACK = 8'h20;
    // command codes
    localparam logic [7:0] CMD_NOP       = 8'h00;
    localparam logic [7:0] CMD_TEACH     = 8'h03;
    localparam logic [7:0] CMD_REBOOT    = 8'h04;
    localparam logic [7:0] CMD_HOLD_CLR  = 8'h11;
    localparam logic [7:0] CMD_TEACH_ACK = 8'h12;
    localparam logic [7:0] CMD_CNT_CLR   = 8'h15;
    localparam logic [7:0] CMD_CNT_STO   = 8'h16;
    // action pulse positions
    localparam int ACT_TEACH = 0;
    localparam int ACT_REBOOT = 1;
    localparam int ACT_HOLD = 2;
    localparam int ACT_TERR = 3;
    localparam int ACT_CCLR = 4;
    localparam int ACT_CSTO = 5;
    localparam int ACT_W = 6;
    // interrupt status bit positions
    localparam int IRQ_RECV = 0;
    localparam int IRQ_ACK  = 1;
    localparam int IRQ_NACK = 2;
    localparam int IRQ_W    = 3;
    // handshake states
    typedef enum logic {S_IDLE, S_RECV} fch_state_e;
endpackage

// ### fch_top.sv
// fieldbus command handshake: apb image registers, trigger detect, decode, irq
`timescale 1ns/1ps
// Function
// - trigger change starts command, not to zero
// - command code alone does nothing
// - argument carries extra data, else ignored
// - input byte 0 echoes executed trigger
// - input byte 1 echoes started command
// - response high byte: idle, received, ack, nack
// - response low byte reserved, reads zero
// - echoes, response and host image reset zero
// - codes 0, 3, 4: nop, teach, reboot
// - codes 17, 18: hold clear, teach-error ack
// - code 21 clears counters with PIN 165
// - code 22 stores counters with PIN 1234
// - counter commands need matching configured PIN
// - triggers ignored while received; echo at answer
// - trigger back to zero clears echoes, response
// - unexecutable command answers with reject
module fch_top
(
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RSTN,
    // apb slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // receiver status pin
    input  wire logic        I_TEACH_OK,
    // command action pulses
    output logic             O_TEACH_START,
    output logic             O_REBOOT,
    output logic             O_HOLD_CLEAR,
    output logic             O_TEACH_ERR_ACK,
    output logic             O_CNT_CLEAR,
    output logic             O_CNT_STORE,
    // interrupt
    output logic             O_IRQ
);
    // bus response flops
    logic [31:0]               prdata_ff;
    logic                      pready_ff;
    logic                      pslverr_ff;
    // host output image
    logic [7:0]                trig_host_ff;
    logic [7:0]                cmd_host_ff;
    logic [15:0]               arg_host_ff;
    // configured pins for the counter commands
    logic [15:0]               pin_clr_ff;
    logic [15:0]               pin_sto_ff;
    // handshake state
    fch_pkg::fch_state_e       state_ff;
    logic [7:0]                seen_ff;      // last trigger accepted
    logic [7:0]                trig_lat_ff;
    logic [7:0]                cmd_lat_ff;
    logic [15:0]               arg_lat_ff;
    logic [7:0]                trig_echo_ff;
    logic [7:0]                cmd_echo_ff;
    logic [7:0]                rsp_ff;       // response high byte
    logic [fch_pkg::ACT_W-1:0] act_ff;
    // interrupt
    logic [fch_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [fch_pkg::IRQ_W-1:0] irq_en_ff;
    logic                      irq_ff;
    // teach-ok synchroniser
    logic                      tok_s1_ff;
    logic                      tok_s2_ff;

    // apb phase decode
    wire apb_acc   = I_PSEL & I_PENABLE;
    wire apb_first = apb_acc & ~pready_ff;
    wire apb_done  = apb_acc & pready_ff;
    wire wr_en     = apb_done & I_PWRITE;

    // address decode
    wire hit_trig = (I_PADDR == fch_pkg::ADR_TRIG);
    wire hit_cmd  = (I_PADDR == fch_pkg::ADR_CMD);
    wire hit_arg  = (I_PADDR == fch_pkg::ADR_ARG);
    wire hit_pclr = (I_PADDR == fch_pkg::ADR_PIN_CLR);
    wire hit_psto = (I_PADDR == fch_pkg::ADR_PIN_STO);
    wire hit_ist  = (I_PADDR == fch_pkg::ADR_IRQ_STAT);
    wire hit_icl  = (I_PADDR == fch_pkg::ADR_IRQ_CLR);
    wire hit_ien  = (I_PADDR == fch_pkg::ADR_IRQ_EN);
    wire addr_ok  = hit_trig | hit_cmd | hit_arg | hit_pclr | hit_psto
                  | hit_ist | hit_icl | hit_ien;

    // read mux; image addresses read back the device's input image
    wire [31:0] rd_data =
        hit_trig ? {24'h000000, trig_echo_ff} :
        hit_cmd  ? {24'h000000, cmd_echo_ff} :
        hit_arg  ? {16'h0000, rsp_ff, 8'h00} :
        hit_pclr ? {16'h0000, pin_clr_ff} :
        hit_psto ? {16'h0000, pin_sto_ff} :
        hit_ist  ? {29'h0, irq_stat_ff} :
        hit_ien  ? {29'h0, irq_en_ff} : 32'h00000000;

    // apb answer: one wait state, data and error latched with pready
    // the wait state keeps every bus output registered at the cost of a cycle
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end
        else
        begin
            pready_ff  <= apb_first;
            pslverr_ff <= apb_first & ~addr_ok;
            prdata_ff  <= (apb_first & ~I_PWRITE) ? rd_data : 32'h00000000;
        end
    end

    // host image and pin registers, written at the completing edge
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            trig_host_ff <= fch_pkg::RST_BYTE;
            cmd_host_ff  <= fch_pkg::RST_BYTE;
            arg_host_ff  <= fch_pkg::RST_WORD;
            pin_clr_ff   <= fch_pkg::RST_PIN_CLR;
            pin_sto_ff   <= fch_pkg::RST_PIN_STO;
            irq_en_ff    <= '0;
        end
        else
        begin
            // image layout: trigger, command, argument
            if (wr_en && hit_trig)
                trig_host_ff <= I_PWDATA[7:0];
            if (wr_en && hit_cmd)
                cmd_host_ff <= I_PWDATA[7:0];
            if (wr_en && hit_arg)
                arg_host_ff <= I_PWDATA[15:0];
            if (wr_en && hit_pclr)
                pin_clr_ff <= I_PWDATA[15:0];
            if (wr_en && hit_psto)
                pin_sto_ff <= I_PWDATA[15:0];
            if (wr_en && hit_ien)
                irq_en_ff <= I_PWDATA[fch_pkg::IRQ_W-1:0];
        end
    end

    // two-flop synchroniser for the asynchronous teach status
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            tok_s1_ff <= 1'b0;
            tok_s2_ff <= 1'b0;
        end
        else
        begin
            tok_s1_ff <= I_TEACH_OK;
            tok_s2_ff <= tok_s1_ff;
        end
    end

    // trigger detection; only a change in idle counts, never into zero
    wire is_idle    = (state_ff == fch_pkg::S_IDLE);
    wire trig_start = is_idle && (trig_host_ff != seen_ff)
                      && (trig_host_ff != 8'h00);
    wire trig_zero  = is_idle && (trig_host_ff == 8'h00) && (seen_ff != 8'h00);

    // decode of the latched command; argument only matters for pin commands
    wire pin_ok_clr = (arg_lat_ff == pin_clr_ff);
    wire pin_ok_sto = (arg_lat_ff == pin_sto_ff);
    wire c_nop  = (cmd_lat_ff == fch_pkg::CMD_NOP);
    wire c_tch  = (cmd_lat_ff == fch_pkg::CMD_TEACH);
    wire c_rbt  = (cmd_lat_ff == fch_pkg::CMD_REBOOT);
    wire c_hold = (cmd_lat_ff == fch_pkg::CMD_HOLD_CLR);
    wire c_terr = (cmd_lat_ff == fch_pkg::CMD_TEACH_ACK);
    wire c_cclr = (cmd_lat_ff == fch_pkg::CMD_CNT_CLR);
    wire c_csto = (cmd_lat_ff == fch_pkg::CMD_CNT_STO);
    // teach error ack is refused until a teach has succeeded
    wire terr_ok = c_terr & tok_s2_ff;
    wire cmd_ack = c_nop | c_tch | c_rbt | c_hold | terr_ok
                 | (c_cclr & pin_ok_clr) | (c_csto & pin_ok_sto);
    wire [fch_pkg::ACT_W-1:0] act_sel = {c_csto & pin_ok_sto, c_cclr & pin_ok_clr,
                                         terr_ok, c_hold, c_rbt, c_tch};

    // handshake sequencer: received for one cycle, then final answer
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            state_ff     <= fch_pkg::S_IDLE;
            seen_ff      <= fch_pkg::RST_BYTE;
            trig_lat_ff  <= fch_pkg::RST_BYTE;
            cmd_lat_ff   <= fch_pkg::RST_BYTE;
            arg_lat_ff   <= fch_pkg::RST_WORD;
            trig_echo_ff <= fch_pkg::RST_BYTE;
            cmd_echo_ff  <= fch_pkg::RST_BYTE;
            rsp_ff       <= fch_pkg::RSP_IDLE;
            act_ff       <= '0;
        end
        else
        begin
            act_ff <= '0;
            case (state_ff)
                fch_pkg::S_IDLE:
                begin
                    if (trig_start)
                    begin
                        // freeze the request against later host writes
                        state_ff    <= fch_pkg::S_RECV;
                        seen_ff     <= trig_host_ff;
                        trig_lat_ff <= trig_host_ff;
                        cmd_lat_ff  <= cmd_host_ff;
                        arg_lat_ff  <= arg_host_ff;
                        cmd_echo_ff <= cmd_host_ff;
                        rsp_ff      <= fch_pkg::RSP_RECV;
                    end
                    else if (trig_zero)
                    begin
                        // host reset its trigger: back to waiting
                        seen_ff      <= fch_pkg::RST_BYTE;
                        trig_echo_ff <= fch_pkg::RST_BYTE;
                        cmd_echo_ff  <= fch_pkg::RST_BYTE;
                        rsp_ff       <= fch_pkg::RSP_IDLE;
                    end
                end
                fch_pkg::S_RECV:
                begin
                    // trigger changes here are ignored; echo set at answer
                    state_ff     <= fch_pkg::S_IDLE;
                    trig_echo_ff <= trig_lat_ff;
                    rsp_ff       <= cmd_ack ? fch_pkg::RSP_ACK : fch_pkg::RSP_NACK;
                    act_ff       <= cmd_ack ? act_sel : '0;
                end
                default:
                begin
                    state_ff <= fch_pkg::S_IDLE;
                end
            endcase
        end
    end

    // interrupt events; a new event beats a clear in the same cycle
    wire in_recv = (state_ff == fch_pkg::S_RECV);
    wire [fch_pkg::IRQ_W-1:0] irq_ev = {in_recv & ~cmd_ack, in_recv & cmd_ack,
                                        trig_start};
    wire [fch_pkg::IRQ_W-1:0] irq_clr = (wr_en && hit_icl)
                                      ? I_PWDATA[fch_pkg::IRQ_W-1:0] : '0;
    wire [fch_pkg::IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;

    // sticky status and level interrupt, registered for a clean output
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            irq_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= |(nxt_irq_stat & irq_en_ff);
        end
    end

    // outputs straight from flops
    assign O_PRDATA        = prdata_ff;
    assign O_PREADY        = pready_ff;
    assign O_PSLVERR       = pslverr_ff;
    assign O_TEACH_START   = act_ff[fch_pkg::ACT_TEACH];
    assign O_REBOOT        = act_ff[fch_pkg::ACT_REBOOT];
    assign O_HOLD_CLEAR    = act_ff[fch_pkg::ACT_HOLD];
    assign O_TEACH_ERR_ACK = act_ff[fch_pkg::ACT_TERR];
    assign O_CNT_CLEAR     = act_ff[fch_pkg::ACT_CCLR];
    assign O_CNT_STORE     = act_ff[fch_pkg::ACT_CSTO];
    assign O_IRQ           = irq_ff;

    // checks on the handshake
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RSTN);

    start_recv_a: assert property (
                      trig_start |=> in_recv && rsp_ff == fch_pkg::RSP_RECV ##1 !in_recv)
        else $error("trigger change did not start a command");
    zero_nostart_a: assert property (is_idle && trig_host_ff == 8'h00 |=> !in_recv)
        else $error("change to zero started a command");
    cause_only_a: assert property (
                      $rose(in_recv) |-> $past(trig_host_ff) != $past(seen_ff))
        else $error("command started without a trigger change");
    cmd_echo_a: assert property (trig_start |=> cmd_echo_ff == $past(cmd_host_ff))
        else $error("command echo not captured");
    trig_echo_a: assert property (
                      trig_start |=> $stable(trig_echo_ff) ##1
                      trig_echo_ff == $past(trig_host_ff, 2))
        else $error("trigger echo timing wrong");
    ack_code_a: assert property (in_recv && cmd_ack |=> rsp_ff == fch_pkg::RSP_ACK)
        else $error("ack code missing");
    zero_clear_a: assert property (trig_zero |=> trig_echo_ff == 8'h00 &&
                      cmd_echo_ff == 8'h00 && rsp_ff == fch_pkg::RSP_IDLE)
        else $error("trigger reset did not clear image");
    pin_reject_a: assert property (in_recv && c_cclr && arg_lat_ff != pin_clr_ff |=>
                      rsp_ff == fch_pkg::RSP_NACK && !O_CNT_CLEAR)
        else $error("wrong pin not rejected");
    terr_reject_a: assert property (in_recv && c_terr && !tok_s2_ff |=>
                      rsp_ff == fch_pkg::RSP_NACK)
        else $error("teach error ack accepted without teach");
    latch_hold_a: assert property (
                      in_recv |=> $stable(cmd_lat_ff) && $stable(arg_lat_ff))
        else $error("latched command changed during execution");

    // bus answer: one wait state, single-cycle ready, error only with ready
    ready_wait_a: assert property (apb_first |=> O_PREADY)
        else $error("ready not given after one wait state");
    ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready stood longer than one cycle");
    err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
        else $error("bus error without ready");
    write_quiet_a: assert property (apb_first && I_PWRITE |=> O_PRDATA == '0)
        else $error("read data driven on a write");
    low_byte_a: assert property (apb_first && !I_PWRITE && hit_arg |=>
                    O_PRDATA[7:0] == 8'h00 && O_PRDATA[31:16] == 16'h0000)
        else $error("reserved response bits not zero");

    // handshake image: quiet while idle, one received cycle, echoes at answer
    idle_quiet_a: assert property (is_idle && !trig_start && !trig_zero |=>
                      $stable(trig_echo_ff) && $stable(cmd_echo_ff) && $stable(rsp_ff))
        else $error("image changed without a trigger event");
    recv_short_a: assert property (in_recv |=> is_idle)
        else $error("received state lasted more than one cycle");
    echo_match_a: assert property (in_recv |=> trig_echo_ff == trig_lat_ff &&
                      cmd_echo_ff == cmd_lat_ff)
        else $error("echo differs from the executed command");

    // decoded commands: each accepted code except nop fires its own pulse with ack
    nop_ack_a: assert property (in_recv && c_nop |=>
                   rsp_ff == fch_pkg::RSP_ACK && act_ff == '0)
        else $error("no-operation not acknowledged quietly");
    teach_go_a: assert property (in_recv && c_tch |=> O_TEACH_START)
        else $error("teach pulse missing");
    reboot_go_a: assert property (in_recv && c_rbt |=> O_REBOOT)
        else $error("reboot pulse missing");
    hold_go_a: assert property (in_recv && c_hold |=> O_HOLD_CLEAR)
        else $error("hold clear pulse missing");
    terr_go_a: assert property (in_recv && c_terr && tok_s2_ff |=> O_TEACH_ERR_ACK)
        else $error("teach error ack pulse missing");
    clr_pin_a: assert property (in_recv && c_cclr && pin_ok_clr |=> O_CNT_CLEAR)
        else $error("counter clear with right pin not done");
    sto_pin_a: assert property (in_recv && c_csto && pin_ok_sto |=> O_CNT_STORE)
        else $error("counter store with right pin not done");
    sto_reject_a: assert property (in_recv && c_csto && !pin_ok_sto |=>
                      rsp_ff == fch_pkg::RSP_NACK && !O_CNT_STORE)
        else $error("wrong store pin not rejected");
    reject_quiet_a: assert property (in_recv && !cmd_ack |=>
                        rsp_ff == fch_pkg::RSP_NACK && act_ff == '0)
        else $error("rejected command fired a pulse");
    pulse_ack_a: assert property (
                     |act_ff |-> rsp_ff == fch_pkg::RSP_ACK && $onehot(act_ff))
        else $error("action pulse without ack");

    // interrupt: level follows enabled status, a new event beats a clear
    irq_level_a: assert property (O_IRQ == (|(irq_stat_ff & $past(irq_en_ff))))
        else $error("interrupt level does not follow status");
    irq_set_a: assert property (trig_start |=> irq_stat_ff[fch_pkg::IRQ_RECV])
        else $error("received event lost");
endmodule

// ### tb.sv
// self-checking bench for the fieldbus command handshake block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module tb;
    logic        I_SYS_CLK;  // 200 MHz system clock
    logic        I_RSTN;     // async reset, active low
    logic        I_TEACH_OK; // receiver reports a good teach
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;      // apb byte address
    logic [31:0] pwdata;     // apb write data
    logic [31:0] prdata;     // apb read data
    wire  [5:0]  act;        // action pulses in package bit order
    logic [5:0]  acc;        // pulses seen since the last clear
    logic        acc_clr;    // clears acc at the next edge
    int          n_fail;
    int          checks;

    // design under test
    fch_top i_dut (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_TEACH_OK(I_TEACH_OK), .O_TEACH_START(act[0]), .O_REBOOT(act[1]),
        .O_HOLD_CLEAR(act[2]), .O_TEACH_ERR_ACK(act[3]), .O_CNT_CLEAR(act[4]),
        .O_CNT_STORE(act[5]), .O_IRQ(irq));

    // host controller on the far side of the register bus
    fch_host_model i_host (.i_clk(I_SYS_CLK), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));

    // clock, 5 ns period
    initial
    begin
        I_SYS_CLK = 1'b0;
        forever #2.5 I_SYS_CLK = ~I_SYS_CLK;
    end

    // pulses last one cycle, so they are collected rather than polled
    always @(posedge I_SYS_CLK)
        acc <= acc_clr ? 6'h00 : (acc | act);

    task automatic wr(input logic [7:0] a, input int d);
        logic [31:0] q;
        logic        e;
        i_host.xfer(1'b1, a, 32'(d), q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
        i_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask

    task automatic clear_acc;
        acc_clr <= 1'b1;
        @(posedge I_SYS_CLK);
        acc_clr <= 1'b0;
    endtask

    // reference: response high byte and expected action for one command
    function automatic int model(input int c, input int a, input int t, output int k);
        k = -1;
        case (c)
            3:  k = fch_pkg::ACT_TEACH;
            4:  k = fch_pkg::ACT_REBOOT;
            17: k = fch_pkg::ACT_HOLD;
            18: if (t == 1) k = fch_pkg::ACT_TERR;
            21: if (a == 165) k = fch_pkg::ACT_CCLR;
            22: if (a == 1234) k = fch_pkg::ACT_CSTO;
            default: ;
        endcase
        return (c == 0 || k >= 0) ? 'h10 : 'h20;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog: the whole sequence needs far fewer cycles than this
    initial
    begin
        #200000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    // main sequence
    initial
    begin
        static int   adr[8] = '{0, 4, 8, 'h0c, 'h10, 'h14, 'h1c, 'h20};
        static int   rv[8]  = '{0, 0, 0, 'ha5, 'h4d2, 0, 0, 0};
        static int   cmds[11] = '{0, 3, 4, 17, 18, 18, 21, 22, 21, 22, 85};
        static int   pins[11] = '{0, 0, 0, 0, 0, 0, 165, 1234, 164, 1235, 0};
        int          i, c, a, hi, k, en, st, trig;
        logic [31:0] q;
        logic        e;
        logic [5:0]  em;
        I_RSTN     = 1'b0;
        I_TEACH_OK = 1'b0;
        acc_clr    = 1'b0;
        n_fail     = 0;
        checks     = 0;
        trig       = 0;
        void'($urandom(4));
        repeat (8) @(posedge I_SYS_CLK);
        I_RSTN <= 1'b1;
        // reset values, plus one unmapped place that must report an error
        for (i = 0; i < 8; i++)
        begin
            rd(8'(adr[i]), q, e);
            `CHK(q, 32'(rv[i]))
            `CHK(e, (i == 7))
        end
        $display("test reset done");
        // every command code, right and wrong PINs, an unknown code
        for (i = 0; i < 11; i++)
        begin
            c  = cmds[i];
            a  = (c == 21 || c == 22) ? pins[i] : int'($urandom_range(65535));
            en = int'($urandom_range(7));
            I_TEACH_OK <= i[0];
            hi = model(c, a, i & 1, k);
            em = (k < 0) ? 6'h00 : 6'(1 << k);
            wr(fch_pkg::ADR_IRQ_EN, en);
            // clear first so that a pulse caused by the bare command write is caught
            clear_acc();
            wr(fch_pkg::ADR_CMD, c);
            wr(fch_pkg::ADR_ARG, a);
            `CHK(acc, 6'h00)
            trig = trig % 255 + 1;
            wr(fch_pkg::ADR_TRIG, trig);
            // a late command write must not touch the command already taken
            wr(fch_pkg::ADR_CMD, c ^ 'h5a);
            rd(fch_pkg::ADR_ARG, q, e);
            `CHK(q, 32'(hi << 8))
            rd(fch_pkg::ADR_TRIG, q, e);
            `CHK(q, 32'(trig))
            rd(fch_pkg::ADR_CMD, q, e);
            `CHK(q, 32'(c))
            `CHK(acc, em)
            st = 1 | ((hi == 'h10) ? 2 : 4);
            rd(fch_pkg::ADR_IRQ_STAT, q, e);
            `CHK(q, 32'(st))
            `CHK(irq, ((st & en) != 0))
            wr(fch_pkg::ADR_IRQ_CLR, 7);
            rd(fch_pkg::ADR_IRQ_STAT, q, e);
            `CHK(q, 32'h0)
            repeat (3) @(posedge I_SYS_CLK);
            `CHK(irq, 1'b0)
            // on odd passes return the trigger to zero; that starts nothing
            if (i % 2 == 1)
            begin
                clear_acc();
                wr(fch_pkg::ADR_TRIG, 0);
                for (k = 0; k < 3; k++)
                begin
                    rd(8'(adr[k]), q, e);
                    `CHK(q, 32'h0)
                end
                `CHK(acc, 6'h00)
            end
            $display("test command %0d done", c);
        end
        report_and_stop();
    end
endmodule
